// >>> psram_cfg_pkg.sv
package psram_cfg_pkg;

  // ----------------------------------------
  // Widths
  // ----------------------------------------
  localparam int REG_W = 16;
  localparam int HI_W = 6;
  localparam int ARR_W = 22;
  localparam int CNT_W = 4;
  localparam int PIN_W = 28;

  // ----------------------------------------
  // Reset values
  // ----------------------------------------
  localparam logic [15:0] BURST_RST = 16'h9D00;
  localparam logic [15:0] REFRESH_RST = 16'h0010;
  // Identification value is arbitrary
  localparam logic [15:0] ID_VALUE = 16'h0C3A;

  // ----------------------------------------
  // Field positions
  // ----------------------------------------
  localparam int B_MODE = 15;
  localparam int B_FIXED = 14;
  localparam int B_LAT_HI = 13;
  localparam int B_LAT_LO = 11;
  localparam int B_WPOL = 10;
  localparam int B_WCFG = 8;
  localparam int R_DEEP = 4;
  localparam int R_PAR_HI = 2;
  localparam int SEL_HI = 3;
  localparam int SEL_LO = 2;

  // ----------------------------------------
  // Register selection
  // ----------------------------------------
  localparam logic [1:0] SEL_REFRESH = 2'h0;
  localparam logic [1:0] SEL_ID = 2'h1;
  localparam logic [1:0] SEL_BURST = 2'h2;
  localparam logic [15:0] SW_REFRESH = 16'h0000;
  localparam logic [15:0] SW_ID = 16'h0002;
  localparam logic [15:0] SW_BURST = 16'h0001;
  localparam logic [21:0] ADDR_TOP = 22'h3FFFFF;
  localparam logic [21:0] ADDR_ZERO = 22'h000000;
  localparam logic [2:0] PAR_NONE = 3'h4;

  // ----------------------------------------
  // Latency codes and counts
  // ----------------------------------------
  localparam logic [2:0] LC_2 = 3'h2;
  localparam logic [2:0] LC_3 = 3'h3;
  localparam logic [2:0] LC_4 = 3'h4;
  localparam logic [2:0] LC_5 = 3'h5;
  localparam logic [2:0] LC_6 = 3'h6;
  localparam logic [2:0] LC_8 = 3'h0;
  localparam logic [3:0] N_2 = 4'h2;
  localparam logic [3:0] N_3 = 4'h3;
  localparam logic [3:0] N_4 = 4'h4;
  localparam logic [3:0] N_5 = 4'h5;
  localparam logic [3:0] N_6 = 4'h6;
  localparam logic [3:0] N_8 = 4'h8;
  localparam logic [3:0] N_ONE = 4'h1;
  localparam logic [1:0] SW_LAST = 2'h2;
  localparam logic [1:0] SW_DATA = 2'h3;

  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam int CLK_PERIOD_NS = 4;
  localparam int CE_EXIT_NS = 10000;
  localparam int INIT_NS = 150000;
  localparam int CE_EXIT_CYC = (CE_EXIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int INIT_CYC = (INIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // ----------------------------------------
  // States
  // ----------------------------------------
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_ARRAY = 3'b010,
    ST_REG = 3'b100
  } acc_state_t;

  typedef enum logic [2:0] {
    PW_ON = 3'b001,
    PW_DEEP = 3'b010,
    PW_INIT = 3'b100
  } pwr_state_t;

endpackage

// >>> pin_sync.sv
module pin_sync #(
  parameter int W = 1
) (
  input wire logic i_core_clk,
  input wire logic i_rst_n,
  input wire logic [W-1:0] i_d,
  output logic [W-1:0] o_q
);

  logic [W-1:0] meta_q;

  // Ones keep the active-low pins idle under reset
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      meta_q <= '1;
      o_q <= '1;
    end else begin
      meta_q <= i_d;
      o_q <= meta_q;
    end
  end

endmodule

// >>> latency_timer.sv
module latency_timer
  import psram_cfg_pkg::*;
(
  input wire logic i_core_clk,
  input wire logic i_rst_n,
  input wire logic i_start,
  input wire logic i_stop,
  input wire logic i_tick,
  output logic [CNT_W-1:0] o_count
);

  logic run_q;
  wire at_max = &o_count;

  // Saturates so a long burst never wraps back into wait
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      run_q <= 1'b0;
      o_count <= '0;
    end else if (i_start) begin
      run_q <= 1'b1;
      o_count <= '0;
    end else if (i_stop) begin
      run_q <= 1'b0;
    end else if (run_q && i_tick && !at_max) begin
      o_count <= o_count + CNT_W'(1);
    end
  end

endmodule

// >>> psram_burst_refresh_config.sv
module psram_burst_refresh_config
#(
  parameter int unsigned INIT_CYCLES = psram_cfg_pkg::INIT_CYC
) (
  input wire logic i_core_clk,
  input wire logic i_rst_n,
  input wire logic i_link_clk,
  input wire logic i_ce_n,
  input wire logic i_adv_n,
  input wire logic i_we_n,
  input wire logic i_oe_n,
  input wire logic i_config_register_select,
  input wire logic [psram_cfg_pkg::HI_W-1:0] i_addr_hi,
  input wire logic [psram_cfg_pkg::REG_W-1:0] i_adq,
  input wire logic i_refresh_collide,
  output logic [psram_cfg_pkg::REG_W-1:0] o_adq,
  output logic o_adq_oe_n,
  output logic o_wait,
  output logic o_wait_oe_n,
  output logic o_data_valid,
  output logic o_deep_sleep_state,
  output logic o_init_busy,
  output logic o_array_lost,
  output logic o_refresh_en,
  output logic [psram_cfg_pkg::ARR_W-1:0] o_refresh_base,
  output logic [psram_cfg_pkg::ARR_W-1:0] o_refresh_last
);
  import psram_cfg_pkg::*;

  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  logic [PIN_W-1:0] pins_s;

  pin_sync #(
    .W(PIN_W)
  ) u_sync (
    .i_core_clk(i_core_clk),
    .i_rst_n(i_rst_n),
    .i_d({i_link_clk, i_ce_n, i_adv_n, i_we_n, i_oe_n,
          i_config_register_select, i_addr_hi, i_adq}),
    .o_q(pins_s)
  );

  wire lclk_s = pins_s[27];
  wire ce_n_s = pins_s[26];
  wire adv_n_s = pins_s[25];
  wire we_n_s = pins_s[24];
  wire oe_n_s = pins_s[23];
  wire cre_s = pins_s[22];
  wire [HI_W-1:0] ahi_s = pins_s[21:16];
  wire [REG_W-1:0] adq_s = pins_s[15:0];
  wire collide = i_refresh_collide;

  // ----------------------------------------
  // Edge detection
  // ----------------------------------------
  logic lclk_q;
  logic ce_n_q;

  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      // Matches the synchroniser's reset level, so no false link edge
      lclk_q <= 1'b1;
      ce_n_q <= 1'b1;
    end else begin
      lclk_q <= lclk_s;
      ce_n_q <= ce_n_s;
    end
  end

  wire link_rise = lclk_s & ~lclk_q;
  wire ce_rise = ce_n_s & ~ce_n_q;

  // ----------------------------------------
  // State declarations
  // ----------------------------------------
  acc_state_t acc_q;
  acc_state_t acc_d;
  pwr_state_t pwr_q;
  logic [REG_W-1:0] burst_q;
  logic [REG_W-1:0] refresh_q;
  logic [1:0] sel_q;
  logic wr_q;
  logic [1:0] sw_cnt_q;
  logic sw_arm_q;
  logic [1:0] sw_sel_q;
  logic [CNT_W-1:0] lat_n_q;
  logic [CNT_W-1:0] lat_cnt;
  logic [11:0] ce_low_q;
  logic [15:0] init_q;

  wire pwr_on = (pwr_q == PW_ON);
  wire addr_phase = link_rise & ~ce_n_s & ~adv_n_s & pwr_on;
  wire data_phase = link_rise & ~ce_n_s & adv_n_s & pwr_on;
  wire [ARR_W-1:0] addr_full = {ahi_s, adq_s};
  wire sw_hit = (addr_full == ADDR_TOP);

  // ----------------------------------------
  // Configuration fields
  // ----------------------------------------
  wire sync_mode = ~burst_q[B_MODE];
  wire fixed_lat = burst_q[B_FIXED];
  wire [2:0] lat_code = burst_q[B_LAT_HI:B_LAT_LO];
  wire wait_hi = burst_q[B_WPOL];
  wire wait_early = burst_q[B_WCFG];
  wire [2:0] par = refresh_q[R_PAR_HI:0];

  // ----------------------------------------
  // Latency count
  // ----------------------------------------
  // Reserved codes fall back to three clocks, six on a variable-latency collision; behaviour there is undefined
  function automatic logic [CNT_W-1:0] lat_count(
    input logic fixed,
    input logic [2:0] code,
    input logic coll
  );
    logic [CNT_W-1:0] n;
    n = N_3;
    if (fixed) begin
      case (code)
        LC_2: n = N_2;
        LC_3: n = N_3;
        LC_4: n = N_4;
        LC_5: n = N_5;
        LC_6: n = N_6;
        LC_8: n = N_8;
        default: n = N_3;
      endcase
    end else begin
      case (code)
        LC_2: n = coll ? N_4 : N_2;
        LC_3: n = coll ? N_6 : N_3;
        LC_4: n = coll ? N_8 : N_4;
        default: n = coll ? N_6 : N_3;
      endcase
    end
    return n;
  endfunction

  // Fixed mode ignores collisions, count is already worst case
  wire [CNT_W-1:0] lat_pick = lat_count(fixed_lat, lat_code, collide & ~fixed_lat);

  // ----------------------------------------
  // Access sequencing
  // ----------------------------------------
  wire to_reg = cre_s | sw_arm_q;
  wire [1:0] new_sel = cre_s ? ahi_s[SEL_HI:SEL_LO] : sw_sel_q;
  wire burst_start = addr_phase & ~to_reg & sync_mode;

  always_comb begin
    acc_d = acc_q;
    case (acc_q)
      ST_IDLE: begin
        if (addr_phase) begin
          acc_d = to_reg ? ST_REG : ST_ARRAY;
        end
      end
      ST_ARRAY, ST_REG: begin
        if (ce_rise) begin
          acc_d = ST_IDLE;
        end else if (addr_phase) begin
          acc_d = to_reg ? ST_REG : ST_ARRAY;
        end
      end
      default: acc_d = ST_IDLE;
    endcase
  end

  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      acc_q <= ST_IDLE;
      sel_q <= SEL_REFRESH;
      wr_q <= 1'b0;
    end else begin
      acc_q <= acc_d;
      if (addr_phase) begin
        sel_q <= new_sel;
        wr_q <= ~we_n_s;
      end
    end
  end

  // ----------------------------------------
  // Software access sequence
  // ----------------------------------------
  // Two reads then a write at the top address; the write data picks the
  // register reached by the next access
  wire sw_read = addr_phase & ~cre_s & sw_hit & we_n_s;
  wire sw_write = addr_phase & ~cre_s & sw_hit & ~we_n_s;
  wire sw_known = (adq_s == SW_REFRESH) | (adq_s == SW_ID) | (adq_s == SW_BURST);

  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      sw_cnt_q <= 2'h0;
      sw_arm_q <= 1'b0;
      sw_sel_q <= SEL_REFRESH;
    end else if (addr_phase && sw_arm_q) begin
      sw_arm_q <= 1'b0;
      sw_cnt_q <= 2'h0;
    end else if (sw_read && sw_cnt_q < SW_LAST) begin
      sw_cnt_q <= sw_cnt_q + 2'h1;
    end else if (sw_write && sw_cnt_q == SW_LAST) begin
      sw_cnt_q <= SW_DATA;
    end else if (addr_phase) begin
      sw_cnt_q <= 2'h0;
    end else if (data_phase && sw_cnt_q == SW_DATA && !we_n_s) begin
      sw_cnt_q <= 2'h0;
      sw_arm_q <= sw_known;
      sw_sel_q <= (adq_s == SW_ID) ? SEL_ID :
                  (adq_s == SW_BURST) ? SEL_BURST : SEL_REFRESH;
    end
  end

  // ----------------------------------------
  // Configuration registers
  // ----------------------------------------
  wire reg_wr = (acc_q == ST_REG) & wr_q & data_phase & ~we_n_s;
  wire deep_entry = ce_rise & ~refresh_q[R_DEEP] & pwr_on;
  wire ce_exit = (pwr_q == PW_DEEP) & (ce_low_q == 12'(CE_EXIT_CYC - 1));
  wire init_done = (pwr_q == PW_INIT) & (init_q == 16'(INIT_CYCLES - 1));

  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      burst_q <= BURST_RST;
    end else if (reg_wr && sel_q == SEL_BURST) begin
      burst_q <= adq_s;
    end
  end

  // Only bit 4 moves in deep sleep; all else is held
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      refresh_q <= REFRESH_RST;
    end else if (ce_exit) begin
      refresh_q[R_DEEP] <= 1'b1;
    end else if (reg_wr && sel_q == SEL_REFRESH) begin
      refresh_q <= adq_s;
    end
  end

  // ----------------------------------------
  // Deep sleep and initialization
  // ----------------------------------------
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      pwr_q <= PW_ON;
    end else begin
      case (pwr_q)
        PW_ON: if (deep_entry) begin
          pwr_q <= PW_DEEP;
        end
        PW_DEEP: if (ce_exit) begin
          pwr_q <= PW_INIT;
        end
        PW_INIT: if (init_done) begin
          pwr_q <= PW_ON;
        end
        default: pwr_q <= PW_ON;
      endcase
    end
  end

  // Any chip select high restarts the 10 us window
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      ce_low_q <= 12'h000;
    end else if (pwr_q != PW_DEEP || ce_n_s) begin
      ce_low_q <= 12'h000;
    end else begin
      ce_low_q <= ce_low_q + 12'h001;
    end
  end

  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      init_q <= 16'h0000;
    end else if (pwr_q != PW_INIT) begin
      init_q <= 16'h0000;
    end else begin
      init_q <= init_q + 16'h0001;
    end
  end

  // ----------------------------------------
  // Burst latency and stall indicator
  // ----------------------------------------
  latency_timer u_lat (
    .i_core_clk(i_core_clk),
    .i_rst_n(i_rst_n),
    .i_start(burst_start),
    .i_stop(ce_rise),
    .i_tick(link_rise),
    .o_count(lat_cnt)
  );

  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      lat_n_q <= N_3;
    end else if (burst_start) begin
      lat_n_q <= lat_pick;
    end
  end

  wire in_burst = (acc_q == ST_ARRAY) & sync_mode & ~ce_n_s;
  wire [CNT_W-1:0] wait_end = wait_early ? (lat_n_q - N_ONE) : lat_n_q;
  wire stall = in_burst & (lat_cnt < wait_end);
  wire data_ok = in_burst & (lat_cnt >= lat_n_q);

  // ----------------------------------------
  // Read-back
  // ----------------------------------------
  wire [REG_W-1:0] rd_val = (sel_q == SEL_BURST) ? burst_q :
                            (sel_q == SEL_ID) ? ID_VALUE : refresh_q;
  wire rd_drive = (acc_q == ST_REG) & ~wr_q & ~oe_n_s & ~ce_n_s;

  // ----------------------------------------
  // Refresh region
  // ----------------------------------------
  // Top regions end at the last word, bottom ones start at zero
  wire [ARR_W-1:0] span = ADDR_TOP >> par[1:0];
  wire [ARR_W-1:0] base_d = par[2] ? (ADDR_TOP - span) : ADDR_ZERO;
  wire [ARR_W-1:0] last_d = par[2] ? ADDR_TOP : span;

  // ----------------------------------------
  // Output registers
  // ----------------------------------------
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_adq <= '0;
      o_adq_oe_n <= 1'b1;
      o_wait <= 1'b0;
      o_wait_oe_n <= 1'b1;
      o_data_valid <= 1'b0;
    end else begin
      o_adq <= rd_drive ? rd_val : '0;
      o_adq_oe_n <= ~rd_drive;
      o_wait <= stall ~^ wait_hi;
      o_wait_oe_n <= ce_n_s;
      o_data_valid <= data_ok;
    end
  end

  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_deep_sleep_state <= 1'b0;
      o_init_busy <= 1'b0;
      o_array_lost <= 1'b0;
      o_refresh_en <= 1'b1;
      o_refresh_base <= ADDR_ZERO;
      o_refresh_last <= ADDR_TOP;
    end else begin
      o_deep_sleep_state <= (pwr_q == PW_DEEP);
      o_init_busy <= (pwr_q == PW_INIT);
      o_array_lost <= deep_entry;
      o_refresh_en <= (pwr_q != PW_DEEP) & (par != PAR_NONE);
      o_refresh_base <= base_d;
      o_refresh_last <= last_d;
    end
  end

endmodule

// >>> psram_cfg_properties.sv
module psram_cfg_properties
  import psram_cfg_pkg::*;
#(
  parameter int unsigned INIT_CYCLES = psram_cfg_pkg::INIT_CYC
) (
  input wire logic i_core_clk,
  input wire logic i_rst_n,
  input wire logic o_wait,
  input wire logic o_data_valid,
  input wire logic o_deep_sleep_state,
  input wire logic o_init_busy,
  input wire logic o_array_lost,
  input wire logic o_refresh_en,
  input wire logic [psram_cfg_pkg::ARR_W-1:0] o_refresh_base,
  input wire logic [psram_cfg_pkg::ARR_W-1:0] o_refresh_last
);
  // ----
  // Helpers
  // ----
  logic [17:0] busy_q;
  logic [17:0] busy_d;
  logic [21:0] span;
  assign busy_d = o_init_busy ? busy_q + 18'h00001 : 18'h00000;
  assign span = o_refresh_last - o_refresh_base;
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      busy_q <= 18'h00000;
    end else begin
      busy_q <= busy_d;
    end
  end
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (!i_rst_n);
  property p_reset_vals;
    $rose(i_rst_n) |-> o_refresh_en && !o_deep_sleep_state && o_refresh_last == ADDR_TOP;
  endproperty
  a_reset_vals: assert property (p_reset_vals) else $error("bad reset refresh");
  property p_region;
    o_refresh_en |-> (o_refresh_base == ADDR_ZERO || o_refresh_last == ADDR_TOP)
      && span inside {22'h3FFFFF, 22'h1FFFFF, 22'h0FFFFF, 22'h07FFFF};
  endproperty
  a_region: assert property (p_region) else $error("bad refresh region");
  property p_sleep_off;
    o_deep_sleep_state && $past(o_deep_sleep_state) |-> !o_refresh_en;
  endproperty
  a_sleep_off: assert property (p_sleep_off) else $error("refresh in sleep");
  property p_lost_entry;
    o_array_lost |-> ##[0:2] o_deep_sleep_state;
  endproperty
  a_lost_entry: assert property (p_lost_entry) else $error("lost without sleep");
  property p_lost_mark;
    $rose(o_deep_sleep_state) |-> $past(o_array_lost);
  endproperty
  a_lost_mark: assert property (p_lost_mark) else $error("sleep without lost mark");
  property p_exit_init;
    $fell(o_deep_sleep_state) |-> ##[0:2] o_init_busy;
  endproperty
  a_exit_init: assert property (p_exit_init) else $error("no init after exit");
  // Tolerance of one cycle either side for the output flop
  property p_init_len;
    $fell(o_init_busy) |-> busy_q >= INIT_CYCLES - 1 && busy_q <= INIT_CYCLES + 1;
  endproperty
  a_init_len: assert property (p_init_len) else $error("bad init length");
  property p_init_quiet;
    o_init_busy |-> !o_deep_sleep_state && !o_data_valid;
  endproperty
  a_init_quiet: assert property (p_init_quiet) else $error("busy during init");
  property p_valid_wait;
    o_data_valid && $past(o_data_valid) |-> $stable(o_wait);
  endproperty
  a_valid_wait: assert property (p_valid_wait) else $error("stall moved in data");
  c_sleep: cover property ($rose(o_deep_sleep_state));
  c_init: cover property ($fell(o_init_busy));
  c_valid: cover property ($rose(o_data_valid));
endmodule

bind psram_burst_refresh_config psram_cfg_properties #(.INIT_CYCLES(INIT_CYCLES)) chk_u (
  .i_core_clk, .i_rst_n, .o_wait, .o_data_valid, .o_deep_sleep_state, .o_init_busy,
  .o_array_lost, .o_refresh_en, .o_refresh_base, .o_refresh_last);

// >>> mem_ctl_model.sv
module mem_ctl_model (
  input wire logic i_core_clk,
  input wire logic [15:0] i_adq,
  input wire logic i_wait,
  input wire logic i_data_valid,
  output logic o_link_clk,
  output logic o_ce_n,
  output logic o_adv_n,
  output logic o_we_n,
  output logic o_oe_n,
  output logic o_config_register_select,
  output logic [5:0] o_addr_hi,
  output logic [15:0] o_adq
);
  timeunit 1ns;
  timeprecision 1ps;
  logic ws [0:15];
  logic vs [0:15];
  initial begin
    o_link_clk = 1'b0;
    o_ce_n = 1'b1;
    o_adv_n = 1'b1;
    o_we_n = 1'b1;
    o_oe_n = 1'b1;
    o_config_register_select = 1'b0;
    o_addr_hi = 6'h00;
    o_adq = 16'h0000;
  end
  // ----
  // Link period, clock still between frames
  // ----
  task automatic lk();
    o_link_clk = 1'b1;
    repeat (6) @(negedge i_core_clk);
    o_link_clk = 1'b0;
    repeat (6) @(negedge i_core_clk);
  endtask
  task automatic access(input logic config_register_select, input logic [21:0] a, input logic we_n,
      input logic [15:0] wd, input int n, output logic [15:0] rd);
    {o_addr_hi, o_adq} = a;
    o_config_register_select = config_register_select;
    o_we_n = we_n;
    o_ce_n = 1'b0;
    o_adv_n = 1'b0;
    lk();
    ws[0] = i_wait;
    vs[0] = i_data_valid;
    o_adv_n = 1'b1;
    o_oe_n = !we_n;
    // Released bus shows the inverse, never a stale value
    o_adq = we_n ? ~a[15:0] : wd;
    for (int k = 1; k <= n; k++) begin
      lk();
      ws[k] = i_wait;
      vs[k] = i_data_valid;
    end
    rd = i_adq;
    o_ce_n = 1'b1;
    o_oe_n = 1'b1;
    o_we_n = 1'b1;
    o_adq = ~o_adq;
    repeat (12) @(negedge i_core_clk);
  endtask
  task automatic hold_ce(input int n);
    o_ce_n = 1'b0;
    repeat (n) @(negedge i_core_clk);
    o_ce_n = 1'b1;
  endtask
endmodule

// >>> testbench.sv
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  import psram_cfg_pkg::*;
  // Short init keeps the run brief
  localparam int unsigned INIT_N = 20;
  logic core_clk = 1'b0;
  logic rst_n = 1'b0;
  logic collide = 1'b0;
  logic link_clk, ce_n, adv_n, we_n, oe_n, config_register_select;
  logic adq_oe_n, wait_pin, wait_oe_n, valid, deep, busy, lost, ref_en;
  logic [5:0] addr_hi;
  logic [15:0] ctl_adq, dut_adq, bus, rd;
  logic [21:0] base, last;
  int fail_count = 0;
  int checked = 0;
  always #2 core_clk = ~core_clk;
  assign bus = adq_oe_n ? ctl_adq : dut_adq;
  psram_burst_refresh_config #(.INIT_CYCLES(INIT_N)) dut_u (
    .i_core_clk(core_clk), .i_rst_n(rst_n), .i_link_clk(link_clk), .i_ce_n(ce_n),
    .i_adv_n(adv_n), .i_we_n(we_n), .i_oe_n(oe_n), .i_config_register_select(config_register_select),
    .i_addr_hi(addr_hi), .i_adq(bus), .i_refresh_collide(collide), .o_adq(dut_adq),
    .o_adq_oe_n(adq_oe_n), .o_wait(wait_pin), .o_wait_oe_n(wait_oe_n),
    .o_data_valid(valid), .o_deep_sleep_state(deep), .o_init_busy(busy),
    .o_array_lost(lost), .o_refresh_en(ref_en), .o_refresh_base(base),
    .o_refresh_last(last));
  mem_ctl_model ctl_u (
    .i_core_clk(core_clk), .i_adq(bus), .i_wait(wait_pin), .i_data_valid(valid),
    .o_link_clk(link_clk), .o_ce_n(ce_n), .o_adv_n(adv_n), .o_we_n(we_n),
    .o_oe_n(oe_n), .o_config_register_select(config_register_select), .o_addr_hi(addr_hi),
    .o_adq(ctl_adq));
  // ----
  // Helpers
  // ----
  task automatic check(input string what, input logic [21:0] seen, input logic [21:0] exp);
    checked++;
    if (seen !== exp) begin
      fail_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic print_verdict();
    $display("checked %0d fail_count %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  task automatic wreg(input logic [1:0] sel, input logic [15:0] d);
    ctl_u.access(1'b1, {2'b00, sel, 18'h00000}, 1'b0, d, 1, rd);
  endtask
  task automatic rreg(input logic [1:0] sel);
    ctl_u.access(1'b1, {2'b00, sel, 18'h00000}, 1'b1, 16'h0000, 1, rd);
  endtask
  task automatic sw_seq(input logic [15:0] code);
    ctl_u.access(1'b0, ADDR_TOP, 1'b1, 16'h0000, 1, rd);
    ctl_u.access(1'b0, ADDR_TOP, 1'b1, 16'h0000, 1, rd);
    ctl_u.access(1'b0, ADDR_TOP, 1'b0, code, 1, rd);
  endtask
  function automatic int lat(input logic fx, input logic [2:0] c, input logic co);
    if (fx) begin
      return (c == LC_8) ? 8 : int'(c);
    end
    return co ? 2 * int'(c) : int'(c);
  endfunction
  function automatic logic [43:0] region(input logic [2:0] c);
    logic [21:0] sz;
    sz = ADDR_TOP >> c[1:0];
    return c[2] ? {ADDR_TOP - sz, ADDR_TOP} : {ADDR_ZERO, sz};
  endfunction
  initial begin
    #100000;
    fail_count++;
    print_verdict();
  end
  initial begin
    logic [43:0] rg;
    logic fx, pol, wc, co, st;
    logic [2:0] code;
    int n;
    void'($urandom(53));
    repeat (10) @(negedge core_clk);
    rst_n = 1'b1;
    repeat (5) @(negedge core_clk);
    rreg(SEL_REFRESH);
    check("refresh reset", rd, REFRESH_RST);
    rreg(SEL_BURST);
    check("burst reset", rd, BURST_RST);
    rreg(SEL_ID);
    check("id", rd, ID_VALUE);
    for (int c = 0; c < 8; c++) begin
      code = 3'(c);
      wreg(SEL_REFRESH, {11'h000, 1'b1, 1'b0, code});
      rg = region(code);
      check("refresh_en", ref_en, code != PAR_NONE);
      if (code != PAR_NONE) begin
        check("base", base, rg[43:22]);
        check("last", last, rg[21:0]);
      end
      rreg(SEL_REFRESH);
      check("readback", rd, {11'h000, 1'b1, 1'b0, code});
    end
    sw_seq(SW_ID);
    ctl_u.access(1'b0, 22'h012345, 1'b1, 16'h0000, 1, rd);
    check("sw id", rd, ID_VALUE);
    sw_seq(SW_REFRESH);
    ctl_u.access(1'b0, ADDR_ZERO, 1'b0, 16'h0003, 1, rd);
    repeat (8) @(negedge core_clk);
    check("deep", deep, 1'b1);
    check("refresh off", ref_en, 1'b0);
    check("wait_oe_n", wait_oe_n, 1'b1);
    ctl_u.hold_ce(CE_EXIT_CYC + 10);
    check("deep exit", deep, 1'b0);
    check("init busy", busy, 1'b1);
    repeat (INIT_N + 10) @(negedge core_clk);
    check("init done", busy, 1'b0);
    rreg(SEL_REFRESH);
    check("refresh kept", rd, 16'h0013);
    rreg(SEL_BURST);
    check("burst kept", rd, BURST_RST);
    for (int i = 0; i < 12; i++) begin
      fx = i >= 6;
      code = fx ? (i == 11 ? LC_8 : 3'(i - 4)) : 3'(2 + i % 3);
      co = fx ? 1'($urandom % 2) : (i >= 3);
      pol = 1'($urandom % 2);
      wc = 1'($urandom % 2);
      wreg(SEL_BURST, {1'b0, fx, code, pol, 1'b0, wc, 8'h00});
      collide = co;
      n = lat(fx, code, co);
      ctl_u.access(1'b0, 22'($urandom), 1'b1, 16'h0000, 10, rd);
      collide = 1'b0;
      for (int k = 0; k <= 10; k++) begin
        st = wc ? k < n - 1 : k < n;
        check("wait", ctl_u.ws[k], pol ? st : !st);
        check("valid", ctl_u.vs[k], k >= n);
      end
    end
    print_verdict();
  end
endmodule
